/* lmpbs_host_model.sv */
`timescale 1ns/10ps
module lmpbs_host_model (
  // Clock
  input wire logic core_clk,
  // Bus pins
  output logic scl,
  output logic sda_drv,
  input wire logic sda_wire
);
  // ----------------------------------------
  // Bus timing
  // ----------------------------------------
  // Eight clocks per phase keeps well above the four-clock minimum
  localparam int PHASE = 8;

  initial begin
    scl = 1'b1;
    sda_drv = 1'b1;
  end

  task automatic wait_clk(input int n);
    repeat (n) @(posedge core_clk);
  endtask

  // Releases the line for the ninth bit and reports the acknowledge
  task automatic send_byte(input logic [7:0] b, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      wait_clk(PHASE / 2);
      sda_drv <= b[i];
      wait_clk(PHASE / 2);
      scl <= 1'b1;
      wait_clk(PHASE);
      scl <= 1'b0;
    end
    wait_clk(PHASE / 2);
    sda_drv <= 1'b1;
    wait_clk(PHASE / 2);
    scl <= 1'b1;
    wait_clk(PHASE / 2);
    ack = (sda_wire === 1'b0);
    wait_clk(PHASE / 2);
    scl <= 1'b0;
  endtask

  task automatic xfer(input logic [6:0] dev, input logic [7:0] bytes[$], output logic ok);
    logic a;
    wait_clk(PHASE);
    sda_drv <= 1'b0;
    wait_clk(PHASE);
    scl <= 1'b0;
    send_byte({dev, 1'b0}, ok);
    foreach (bytes[i]) begin
      send_byte(bytes[i], a);
      ok = ok & a;
    end
    wait_clk(PHASE / 2);
    sda_drv <= 1'b0;
    wait_clk(PHASE / 2);
    scl <= 1'b1;
    wait_clk(PHASE);
    sda_drv <= 1'b1;
    wait_clk(PHASE);
  endtask

  // Unlock first, then one page change
  task automatic set_page(input logic [7:0] p);
    logic ok;
    xfer(lmpbs_pkg::DEV_ADDR_DEFAULT, '{lmpbs_pkg::REG_LOCK, lmpbs_pkg::UNLOCK_KEY}, ok);
    xfer(lmpbs_pkg::DEV_ADDR_DEFAULT, '{lmpbs_pkg::REG_PAGE_SEL, p}, ok);
  endtask

  // Same selector into all four bytes of the dot
  task automatic set_mode(input logic [7:0] ptr, input logic [7:0] m);
    logic ok;
    xfer(lmpbs_pkg::DEV_ADDR_DEFAULT, '{ptr, m, m}, ok);
    xfer(lmpbs_pkg::DEV_ADDR_DEFAULT, '{ptr + lmpbs_pkg::HALF_STRIDE, m, m}, ok);
  endtask
endmodule

/* lmpbs_i2c_slave.sv */
`timescale 1ns/10ps
module lmpbs_i2c_slave #(
  parameter logic [6:0] DEV_ADDR = lmpbs_pkg::DEV_ADDR_DEFAULT
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // Bus pins
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  // Register write port
  output logic wr_stb,
  output logic [7:0] wr_addr,
  output logic [7:0] wr_data
);

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  logic scl_s1_r, scl_s2_r, scl_d_r;
  logic sda_s1_r, sda_s2_r, sda_d_r;

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      scl_s1_r <= 1'b1;
      scl_s2_r <= 1'b1;
      scl_d_r <= 1'b1;
      sda_s1_r <= 1'b1;
      sda_s2_r <= 1'b1;
      sda_d_r <= 1'b1;
    end else begin
      scl_s1_r <= scl_in;
      scl_s2_r <= scl_s1_r;
      scl_d_r <= scl_s2_r;
      sda_s1_r <= sda_in;
      sda_s2_r <= sda_s1_r;
      sda_d_r <= sda_s2_r;
    end
  end

  logic scl_rise, scl_fall, start_seen, stop_seen;
  assign scl_rise = scl_s2_r & ~scl_d_r;
  assign scl_fall = ~scl_s2_r & scl_d_r;
  assign start_seen = scl_s2_r & scl_d_r & sda_d_r & ~sda_s2_r;
  assign stop_seen = scl_s2_r & scl_d_r & ~sda_d_r & sda_s2_r;

  // ----------------------------------------
  // Byte engine
  // ----------------------------------------
  lmpbs_pkg::lmpbs_bus_t state_r;
  logic [3:0] bit_cnt_r;
  logic [7:0] shift_r;
  logic ack_r;

  // Reads are not served: the address is not acknowledged with the read bit set
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      state_r <= lmpbs_pkg::BUS_IDLE;
      bit_cnt_r <= 4'h0;
      shift_r <= 8'h00;
      ack_r <= 1'b0;
      wr_stb <= 1'b0;
      wr_addr <= 8'h00;
      wr_data <= 8'h00;
    end else begin
      wr_stb <= 1'b0;
      if (start_seen) begin
        state_r <= lmpbs_pkg::BUS_ADDR;
        bit_cnt_r <= 4'h0;
        ack_r <= 1'b0;
      end else if (stop_seen) begin
        state_r <= lmpbs_pkg::BUS_IDLE;
        ack_r <= 1'b0;
      end else if (state_r != lmpbs_pkg::BUS_IDLE) begin
        if (scl_rise && bit_cnt_r < 4'h8) begin
          shift_r <= {shift_r[6:0], sda_s2_r};
          bit_cnt_r <= bit_cnt_r + 4'h1;
        end else if (scl_fall && ack_r) begin
          ack_r <= 1'b0;
          bit_cnt_r <= 4'h0;
        end else if (scl_fall && bit_cnt_r == 4'h8) begin
          unique case (state_r)
            lmpbs_pkg::BUS_ADDR: begin
              if (shift_r[7:1] == DEV_ADDR && !shift_r[0]) begin
                ack_r <= 1'b1;
                state_r <= lmpbs_pkg::BUS_PTR;
              end else begin
                state_r <= lmpbs_pkg::BUS_IDLE;
              end
            end
            lmpbs_pkg::BUS_PTR: begin
              ack_r <= 1'b1;
              wr_addr <= shift_r;
              state_r <= lmpbs_pkg::BUS_DATA;
            end
            lmpbs_pkg::BUS_DATA: begin
              ack_r <= 1'b1;
              wr_stb <= 1'b1;
              wr_data <= shift_r;
            end
            lmpbs_pkg::BUS_IDLE: begin
              ack_r <= 1'b0;
            end
          endcase
        end
        // Pointer advances once the strobe has been taken
        if (wr_stb) begin
          wr_addr <= wr_addr + 8'h01;
        end
      end
    end
  end

  assign sda_out = 1'b0;
  assign sda_oe = ack_r;

endmodule

/* lmpbs_pkg.sv */
package lmpbs_pkg;

  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int CLK_PERIOD_NS = 4;
  localparam int SLOT_TIME_NS = 128000;
  localparam int GAP_TIME_NS = 8000;
  localparam int SLOT_CYC = (SLOT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int GAP_CYC = (GAP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PWM_LEVELS = 512;

  // ----------------------------------------
  // Matrix geometry
  // ----------------------------------------
  localparam int ROWS = 6;
  localparam int COLS = 8;
  localparam int LEGS = 2;
  localparam int PAGE_BYTES = 192;
  localparam logic [7:0] PAGE_LAST = 8'hbf;
  localparam logic [7:0] ROW_STRIDE = 8'h20;
  localparam logic [7:0] HALF_STRIDE = 8'h10;
  localparam logic [7:0] COL_STRIDE = 8'h02;

  // ----------------------------------------
  // Register map
  // ----------------------------------------
  localparam logic [7:0] PAGE_DUTY = 8'h01;
  localparam logic [7:0] PAGE_MODE = 8'h02;
  localparam logic [7:0] PAGE_FUNC = 8'h03;
  localparam logic [7:0] REG_PAGE_SEL = 8'hfd;
  localparam logic [7:0] REG_LOCK = 8'hfe;
  localparam logic [7:0] UNLOCK_KEY = 8'hc5;
  localparam logic [7:0] LOCK_RESET = 8'h00;
  localparam logic [7:0] PAGE_RESET = 8'h00;
  localparam logic [7:0] FUNC_CONFIG = 8'h00;
  localparam logic [7:0] FUNC_CURRENT_CODE = 8'h01;
  localparam int CFG_RUN_BIT = 0;
  localparam int CFG_BREATH_BIT = 1;
  localparam logic [7:0] CFG_RESET = 8'h00;
  localparam logic [7:0] CURRENT_CODE_RESET = 8'h00;
  localparam logic [7:0] DUTY_RESET = 8'h00;
  localparam logic [6:0] DEV_ADDR_DEFAULT = 7'h50;

  typedef enum logic [1:0] {
    MODE_DIRECT = 2'b00,
    MODE_PROFILE_ONE = 2'b01,
    MODE_PROFILE_TWO = 2'b10,
    MODE_PROFILE_THREE = 2'b11
  } lmpbs_mode_t;

  typedef enum logic {
    SCAN_ACTIVE = 1'b0,
    SCAN_GAP = 1'b1
  } lmpbs_scan_t;

  typedef enum logic [1:0] {
    BUS_IDLE = 2'b00,
    BUS_ADDR = 2'b01,
    BUS_PTR = 2'b10,
    BUS_DATA = 2'b11
  } lmpbs_bus_t;

  // Byte offset of one leg of one dot in either page
  function automatic logic [7:0] dot_index(input logic [2:0] row, input logic half,
                                           input logic [2:0] col, input logic leg);
    dot_index = 8'(row * ROW_STRIDE) + (half ? HALF_STRIDE : 8'h00)
                + 8'(col * COL_STRIDE) + {7'h00, leg};
  endfunction

endpackage

/* lmpbs_top.sv */
`timescale 1ns/10ps
module lmpbs_top #(
  parameter int unsigned ACTIVE_CYCLES = lmpbs_pkg::SLOT_CYC,
  parameter logic [6:0] DEV_ADDR = lmpbs_pkg::DEV_ADDR_DEFAULT
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // Host bus pins
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  // Breathing levels from the profile generators
  input wire logic [7:0] breath_profile_one,
  input wire logic [7:0] breath_profile_two,
  input wire logic [7:0] breath_profile_three,
  // Matrix drive
  output logic [5:0] row_scan_switch,
  output logic [15:0] column_current_source,
  output logic [7:0] global_current_code,
  output logic breath_enable
);

  localparam int unsigned GAP_CYCLES = lmpbs_pkg::GAP_CYC;

  // ----------------------------------------
  // Host bus
  // ----------------------------------------
  logic wr_stb;
  logic [7:0] wr_addr, wr_data;
  logic sda_out_w, sda_oe_w;

  lmpbs_i2c_slave #(
    .DEV_ADDR(DEV_ADDR)
  ) lmpbs_i2c_slave_inst (
    .core_clk(core_clk),
    .reset(reset),
    .scl_in(scl_in),
    .sda_in(sda_in),
    .sda_out(sda_out_w),
    .sda_oe(sda_oe_w),
    .wr_stb(wr_stb),
    .wr_addr(wr_addr),
    .wr_data(wr_data)
  );

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      sda_out <= 1'b0;
      sda_oe <= 1'b0;
    end else begin
      sda_out <= sda_out_w;
      sda_oe <= sda_oe_w;
    end
  end

  // ----------------------------------------
  // Page select and write lock
  // ----------------------------------------
  logic [7:0] lock_r, page_r;
  logic page_wr, lock_wr, unlocked;
  assign lock_wr = wr_stb && wr_addr == lmpbs_pkg::REG_LOCK;
  assign page_wr = wr_stb && wr_addr == lmpbs_pkg::REG_PAGE_SEL;
  assign unlocked = lock_r == lmpbs_pkg::UNLOCK_KEY;

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      lock_r <= lmpbs_pkg::LOCK_RESET;
    end else if (lock_wr) begin
      lock_r <= wr_data;
    end else if (page_wr && unlocked) begin
      lock_r <= lmpbs_pkg::LOCK_RESET;
    end
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      page_r <= lmpbs_pkg::PAGE_RESET;
    end else if (page_wr && unlocked) begin
      page_r <= wr_data;
    end
  end

  // ----------------------------------------
  // Per-dot storage
  // ----------------------------------------
  logic [7:0] duty_mem [lmpbs_pkg::PAGE_BYTES];
  logic [1:0] mode_mem [lmpbs_pkg::PAGE_BYTES];
  logic in_page, duty_wr, mode_wr;
  assign in_page = wr_stb && wr_addr <= lmpbs_pkg::PAGE_LAST;
  assign duty_wr = in_page && page_r == lmpbs_pkg::PAGE_DUTY;
  assign mode_wr = in_page && page_r == lmpbs_pkg::PAGE_MODE;

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      for (int i = 0; i < lmpbs_pkg::PAGE_BYTES; i++) begin
        duty_mem[i] <= lmpbs_pkg::DUTY_RESET;
      end
    end else if (duty_wr) begin
      duty_mem[wr_addr] <= wr_data;
    end
  end

  // Upper six bits of a selector write are dropped
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      for (int i = 0; i < lmpbs_pkg::PAGE_BYTES; i++) begin
        mode_mem[i] <= lmpbs_pkg::MODE_DIRECT;
      end
    end else if (mode_wr) begin
      mode_mem[wr_addr] <= wr_data[1:0];
    end
  end

  // ----------------------------------------
  // Function page
  // ----------------------------------------
  logic [7:0] cfg_r;
  logic func_wr;
  assign func_wr = wr_stb && page_r == lmpbs_pkg::PAGE_FUNC;

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      cfg_r <= lmpbs_pkg::CFG_RESET;
    end else if (func_wr && wr_addr == lmpbs_pkg::FUNC_CONFIG) begin
      cfg_r <= wr_data;
    end
  end

  // The analog stage doubles this code over 256 against the resistor reference
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      global_current_code <= lmpbs_pkg::CURRENT_CODE_RESET;
    end else if (func_wr && wr_addr == lmpbs_pkg::FUNC_CURRENT_CODE) begin
      global_current_code <= wr_data;
    end
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      breath_enable <= 1'b0;
    end else begin
      breath_enable <= cfg_r[lmpbs_pkg::CFG_BREATH_BIT];
    end
  end

  // ----------------------------------------
  // Row scan
  // ----------------------------------------
  lmpbs_pkg::lmpbs_scan_t scan_r;
  logic [15:0] scan_cnt_r;
  logic [2:0] row_r;
  logic slot_end, gap_end;
  assign slot_end = scan_r == lmpbs_pkg::SCAN_ACTIVE && scan_cnt_r == 16'(ACTIVE_CYCLES - 1);
  assign gap_end = scan_r == lmpbs_pkg::SCAN_GAP && scan_cnt_r == 16'(GAP_CYCLES - 1);

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      scan_r <= lmpbs_pkg::SCAN_ACTIVE;
      scan_cnt_r <= 16'h0000;
      row_r <= 3'h0;
    end else begin
      unique case (scan_r)
        lmpbs_pkg::SCAN_ACTIVE: begin
          if (slot_end) begin
            scan_r <= lmpbs_pkg::SCAN_GAP;
            scan_cnt_r <= 16'h0000;
          end else begin
            scan_cnt_r <= scan_cnt_r + 16'h0001;
          end
        end
        lmpbs_pkg::SCAN_GAP: begin
          if (gap_end) begin
            scan_r <= lmpbs_pkg::SCAN_ACTIVE;
            scan_cnt_r <= 16'h0000;
            row_r <= (row_r == 3'(lmpbs_pkg::ROWS - 1)) ? 3'h0 : row_r + 3'h1;
          end else begin
            scan_cnt_r <= scan_cnt_r + 16'h0001;
          end
        end
      endcase
    end
  end

  // ----------------------------------------
  // PWM phase
  // ----------------------------------------
  // Spreads 512 steps evenly over the slot even when the slot is not a multiple of 512
  logic [17:0] acc_r, acc_sum;
  logic [8:0] step_r;
  assign acc_sum = acc_r + 18'(lmpbs_pkg::PWM_LEVELS);

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      acc_r <= 18'h00000;
      step_r <= 9'h000;
    end else if (scan_r == lmpbs_pkg::SCAN_GAP) begin
      acc_r <= 18'h00000;
      step_r <= 9'h000;
    end else if (acc_sum >= 18'(ACTIVE_CYCLES)) begin
      acc_r <= acc_sum - 18'(ACTIVE_CYCLES);
      step_r <= step_r + 9'h001;
    end else begin
      acc_r <= acc_sum;
    end
  end

  // ----------------------------------------
  // Column drive
  // ----------------------------------------
  // Step bit 8 picks the half slot, so each byte owns half the slot on its own leg
  logic [15:0] col_nxt;
  always_comb begin
    logic [7:0] idx;
    logic [7:0] level;
    idx = 8'h00;
    level = 8'h00;
    col_nxt = 16'h0000;
    for (int c = 0; c < lmpbs_pkg::COLS; c++) begin
      for (int l = 0; l < lmpbs_pkg::LEGS; l++) begin
        idx = lmpbs_pkg::dot_index(row_r, step_r[8], 3'(c), 1'(l));
        // Each byte follows its own selector, relying on the host keeping the four equal
        unique case (lmpbs_pkg::lmpbs_mode_t'(mode_mem[idx]))
          lmpbs_pkg::MODE_DIRECT: level = duty_mem[idx];
          lmpbs_pkg::MODE_PROFILE_ONE: level = breath_profile_one;
          lmpbs_pkg::MODE_PROFILE_TWO: level = breath_profile_two;
          lmpbs_pkg::MODE_PROFILE_THREE: level = breath_profile_three;
        endcase
        if (!cfg_r[lmpbs_pkg::CFG_BREATH_BIT]) begin
          level = duty_mem[idx];
        end
        col_nxt[2 * c + l] = cfg_r[lmpbs_pkg::CFG_RUN_BIT] && scan_r == lmpbs_pkg::SCAN_ACTIVE
                             && step_r[7:0] < level;
      end
    end
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      column_current_source <= 16'h0000;
      row_scan_switch <= 6'h00;
    end else begin
      column_current_source <= col_nxt;
      row_scan_switch <= (scan_r == lmpbs_pkg::SCAN_ACTIVE) ? 6'(6'h01 << row_r) : 6'h00;
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  chk_lock_rearm: assert property (@(posedge core_clk) disable iff (reset)
    (page_wr && unlocked && !lock_wr) |=> (lock_r == lmpbs_pkg::LOCK_RESET && page_r == $past(wr_data)))
    else $error("lock did not rearm after page change");

  chk_page_locked: assert property (@(posedge core_clk) disable iff (reset)
    (page_wr && !unlocked) |=> $stable(page_r))
    else $error("page changed while locked");

  chk_duty_store: assert property (@(posedge core_clk) disable iff (reset)
    duty_wr |=> duty_mem[$past(wr_addr)] == $past(wr_data))
    else $error("duty byte not stored");

  chk_mode_store: assert property (@(posedge core_clk) disable iff (reset)
    mode_wr |=> mode_mem[$past(wr_addr)] == $past(wr_data[1:0]))
    else $error("mode selector not stored");

  chk_code_store: assert property (@(posedge core_clk) disable iff (reset)
    (func_wr && wr_addr == lmpbs_pkg::FUNC_CURRENT_CODE) |=> global_current_code == $past(wr_data))
    else $error("global current code not taken");

  chk_gap_dark: assert property (@(posedge core_clk) disable iff (reset)
    slot_end |=> ##1 (row_scan_switch == 6'h00 && column_current_source == 16'h0000) [*8])
    else $error("drive active during gap");

  chk_row_advance: assert property (@(posedge core_clk) disable iff (reset)
    gap_end |=> (scan_r == lmpbs_pkg::SCAN_ACTIVE && row_r != $past(row_r)
                 && row_r < 3'(lmpbs_pkg::ROWS)))
    else $error("row did not advance after gap");

  chk_step_full: assert property (@(posedge core_clk) disable iff (reset)
    slot_end |-> step_r == 9'(lmpbs_pkg::PWM_LEVELS - 1))
    else $error("slot did not span 512 steps");

  chk_shutdown_dark: assert property (@(posedge core_clk) disable iff (reset)
    !cfg_r[lmpbs_pkg::CFG_RUN_BIT] |=> column_current_source == 16'h0000)
    else $error("columns driven in shutdown");

  chk_row_onehot: assert property (@(posedge core_clk) disable iff (reset)
    $onehot0(row_scan_switch))
    else $error("more than one row switch on");

  chk_row_drive: assert property (@(posedge core_clk) disable iff (reset)
    gap_end |=> ##1 row_scan_switch == 6'(6'h01 << $past(row_r)))
    else $error("wrong row driven after gap");

  chk_step_restart: assert property (@(posedge core_clk) disable iff (reset)
    gap_end |=> step_r == 9'h000)
    else $error("phase did not restart with the slot");

  chk_lock_store: assert property (@(posedge core_clk) disable iff (reset)
    lock_wr |=> lock_r == $past(wr_data))
    else $error("lock byte not stored");

  chk_enable_copy: assert property (@(posedge core_clk) disable iff (reset)
    1'b1 |=> breath_enable == $past(cfg_r[lmpbs_pkg::CFG_BREATH_BIT]))
    else $error("breath enable does not follow config");

endmodule

/* test_led_matrix_pwm_breath_select.sv */
`timescale 1ns/10ps
module test_led_matrix_pwm_breath_select;
  // ----------------------------------------
  // Bench setup
  // ----------------------------------------
  // Short slot: one PWM step per clock keeps the run small
  localparam int ACT = 512;
  localparam logic [6:0] DEV = lmpbs_pkg::DEV_ADDR_DEFAULT;
  logic core_clk = 1'b0;
  logic reset = 1'b1;
  logic scl, sda_drv, sda_out, sda_oe, breath_enable, ok;
  logic [7:0] p1 = 8'h10, p2 = 8'h30, p3 = 8'h50;
  logic [5:0] row_scan_switch;
  logic [15:0] column_current_source;
  logic [7:0] global_current_code;
  wire logic sda_wire = (sda_oe === 1'b1) ? sda_out : sda_drv;
  int fails = 0;
  int n_checks = 0;
  int on[16];
  int len, gap;

  always #2 core_clk = ~core_clk;

  lmpbs_top #(.ACTIVE_CYCLES(ACT), .DEV_ADDR(DEV)) lmpbs_top_inst (
    .core_clk(core_clk), .reset(reset), .scl_in(scl), .sda_in(sda_wire),
    .sda_out(sda_out), .sda_oe(sda_oe), .breath_profile_one(p1),
    .breath_profile_two(p2), .breath_profile_three(p3),
    .row_scan_switch(row_scan_switch), .column_current_source(column_current_source),
    .global_current_code(global_current_code), .breath_enable(breath_enable));

  lmpbs_host_model lmpbs_host_model_inst (
    .core_clk(core_clk), .scl(scl), .sda_drv(sda_drv), .sda_wire(sda_wire));

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic conclude();
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED %s expected %0h seen %0h", name, exp, seen);
    end
  endtask

  // Per-leg on-cycles over one fresh slot of a row, then the gap after it
  task automatic measure(input int row);
    int k;
    k = 0;
    while (row_scan_switch[row] === 1'b1 && k < 40000) begin
      @(posedge core_clk);
      k++;
    end
    while (row_scan_switch[row] !== 1'b1 && k < 40000) begin
      @(posedge core_clk);
      k++;
    end
    foreach (on[i]) on[i] = 0;
    len = 0;
    gap = 0;
    while (row_scan_switch[row] === 1'b1 && k < 40000) begin
      foreach (on[i]) on[i] += (column_current_source[i] === 1'b1);
      len++;
      @(posedge core_clk);
      k++;
    end
    while (row_scan_switch === 6'h00 && k < 40000) begin
      gap++;
      @(posedge core_clk);
      k++;
    end
    if (k >= 40000) begin
      fails++;
      conclude();
    end
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset();
    check("code", global_current_code, 8'h00);
    check("benable", breath_enable, 1'b0);
    check("columns", column_current_source, 16'h0000);
  endtask

  task automatic t_lock();
    lmpbs_host_model_inst.xfer(DEV ^ 7'h01, '{8'hfe, 8'h00}, ok);
    check("nack", ok, 1'b0);
    lmpbs_host_model_inst.xfer(DEV, '{8'hfd, 8'h03}, ok);
    check("ack", ok, 1'b1);
    lmpbs_host_model_inst.xfer(DEV, '{8'h01, 8'h5a}, ok);
    check("code_locked", global_current_code, 8'h00);
    lmpbs_host_model_inst.set_page(lmpbs_pkg::PAGE_FUNC);
    lmpbs_host_model_inst.xfer(DEV, '{8'h01, 8'hb5}, ok);
    check("code_set", global_current_code, 8'hb5);
    // Lock must have closed again after the one page change
    lmpbs_host_model_inst.xfer(DEV, '{8'hfd, 8'h01}, ok);
    lmpbs_host_model_inst.xfer(DEV, '{8'h00, 8'h01, 8'h22}, ok);
    check("code_relock", global_current_code, 8'h22);
  endtask

  task automatic t_duty();
    lmpbs_host_model_inst.set_page(lmpbs_pkg::PAGE_DUTY);
    lmpbs_host_model_inst.xfer(DEV, '{8'h00, 8'h80, 8'h40}, ok);
    lmpbs_host_model_inst.xfer(DEV, '{8'h10, 8'h00, 8'hff}, ok);
    lmpbs_host_model_inst.xfer(DEV, '{8'h4e, 8'h20}, ok);
    lmpbs_host_model_inst.xfer(DEV, '{8'hbf, 8'h77}, ok);
    measure(0);
    check("slot_len", len, ACT);
    check("gap_len", gap, lmpbs_pkg::GAP_CYC);
    check("a1_leg0", on[0], 32'h80 * ACT / 512);
    check("a1_leg1", on[1], (32'h40 + 32'hff) * ACT / 512);
    check("a_unused", on[2], 0);
    measure(2);
    check("c8_leg0", on[14], 32'h20 * ACT / 512);
    measure(5);
    check("f8_leg1", on[15], 32'h77 * ACT / 512);
  endtask

  task automatic t_breath();
    logic [7:0] lvl[4];
    lvl = '{8'h00, p1, p2, p3};
    lmpbs_host_model_inst.set_page(lmpbs_pkg::PAGE_MODE);
    lmpbs_host_model_inst.set_mode(8'h00, 8'h01);
    measure(0);
    check("ben_off", on[0], 32'h80 * ACT / 512);
    lmpbs_host_model_inst.set_page(lmpbs_pkg::PAGE_FUNC);
    lmpbs_host_model_inst.xfer(DEV, '{8'h00, 8'h03}, ok);
    check("benable", breath_enable, 1'b1);
    lmpbs_host_model_inst.set_page(lmpbs_pkg::PAGE_MODE);
    for (int m = 1; m < 4; m++) begin
      // Upper bits set to show they are ignored
      lmpbs_host_model_inst.set_mode(8'h00, {6'h2a, 2'(m)});
      measure(0);
      check("prof_leg0", on[0], 2 * lvl[m] * ACT / 512);
      check("prof_leg1", on[1], 2 * lvl[m] * ACT / 512);
    end
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    repeat (10) @(posedge core_clk);
    reset <= 1'b0;
    repeat (4) @(posedge core_clk);
    t_reset();
    t_lock();
    t_duty();
    t_breath();
    conclude();
  end
endmodule
